/* File: rtl/reset_timeout_sequencer.sv */
`timescale 1ns/1ps
`include "rst_seq_params.svh"
module reset_timeout_sequencer
   import rst_seq_pkg::*;
#(
   parameter int CLK_HZ = 40000000,
   parameter int POWERUP_DELAY_TIMER_MS = `PWRUP_DELAY_MS,
   parameter int RC_HZ = `PWRUP_RC_HZ,
   parameter int OST_CYCLES = `OSC_STARTUP_CYCLES,
   parameter int FILT_CYCLES = `MASTER_CLEAR_PIN_FILTER_CYCLES,
   parameter int BOD_CYCLES = `BOD_MIN_CYCLES
)(
   // clock and reset
   input wire logic SYS_CLK_I,
   input wire logic RST_I,
   // supply monitors
   input wire logic POR_PULSE_I,
   input wire logic SUPPLY_OK_I,
   input wire logic BELOW_TRIP_I,
   // pins and sources
   input wire logic MASTER_CLEAR_PIN_N_I,
   input wire logic OSCILLATOR_INPUT_PIN_I,
   input wire logic PWRUP_RC_TICK_I,
   input wire logic WATCHDOG_TIMER_EXPIRE_I,
   // configuration word
   input wire logic POWERUP_DELAY_ENABLE_N_I,
   input wire logic BROWNOUT_ENABLE_I,
   input wire logic MASTER_CLEAR_PIN_PIN_ENABLE_I,
   input wire logic [2:0] OSC_MODE_I,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [31:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // reset outputs
   output logic CHIP_RESET_O,
   output logic STATE_RESET_O,
   output logic WAKE_O,
   output logic MASTER_CLEAR_PIN_OE_O
);
   localparam int POWERUP_DELAY_TIMER_TICKS = (POWERUP_DELAY_TIMER_MS * RC_HZ) / 1000;
   localparam int PW = $clog2(POWERUP_DELAY_TIMER_TICKS + 1);
   localparam int OW = $clog2(OST_CYCLES + 1);
   localparam int FW = $clog2(FILT_CYCLES + 1);
   localparam int BW = $clog2(BOD_CYCLES + 1);

   seq_state_e state_reg, state_next;
   logic [PW-1:0] powerup_delay_timer_cnt_reg;
   logic [OW-1:0] ost_cnt_reg;
   logic [FW-1:0] filt_cnt_reg;
   logic [BW-1:0] bod_cnt_reg;
   logic pin_low_reg, osc_prev_reg, sleep_reg, by_por_reg;
   logic por_flag_reg, bod_flag_reg, to_flag_reg, pd_flag_reg;
   cause_e cause_reg;
   logic [7:0] retain_reg, state_rst_reg;

   // source detection
   wire crystal = (OSC_MODE_I == OSC_LP) || (OSC_MODE_I == OSC_XT) || (OSC_MODE_I == OSC_HS);
   wire pin_raw_low = MASTER_CLEAR_PIN_PIN_ENABLE_I && !MASTER_CLEAR_PIN_N_I;
   wire master_clear_pin_evt = pin_low_reg && (state_reg == ST_RUN); // see [RULE5] [RULE20]
   wire bod_evt = BROWNOUT_ENABLE_I && (bod_cnt_reg == BW'(BOD_CYCLES)); // see [RULE14] [RULE15]
   wire wdt_run = WATCHDOG_TIMER_EXPIRE_I && !sleep_reg;
   wire wdt_wake = WATCHDOG_TIMER_EXPIRE_I && sleep_reg;
   wire supply_low = BROWNOUT_ENABLE_I && !SUPPLY_OK_I;
   wire osc_edge = OSCILLATOR_INPUT_PIN_I && !osc_prev_reg;
   // power-on pulse, filtered pin, watchdog in run, or a long supply dip when brown-out is enabled
   wire hard_rst = POR_PULSE_I || master_clear_pin_evt || bod_evt || wdt_run; // see [RULE8] [RULE1]
   wire need_ost = crystal && (by_por_reg || cause_reg == CAUSE_WDT_WAKE); // see [RULE13]

   // apb decode
   wire sel_ctrl = PADDR == `REG_CTRL;
   wire sel_stat = PADDR == `REG_STATUS;
   wire sel_ret = PADDR == `REG_RETAIN;
   wire mapped = sel_ctrl || sel_stat || sel_ret;
   wire apb_wr = PSEL && PENABLE && PWRITE && PREADY; // lands at the ready edge
   wire apb_rd = PSEL && PENABLE && !PWRITE && !PREADY;
   wire [31:0] rd_mux = sel_ctrl ? {31'h0000_0000, sleep_reg} :
      sel_stat ? {25'h000_0000, cause_reg, pd_flag_reg, to_flag_reg, bod_flag_reg,
                  por_flag_reg} :
      sel_ret ? {24'h00_0000, retain_reg} : 32'h0000_0000;

   // sequencer next state
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         ST_HOLD: if (!POR_PULSE_I && !supply_low) // see [RULE7] [RULE16] [RULE18]
            state_next = (by_por_reg && !POWERUP_DELAY_ENABLE_N_I) ? ST_POWERUP_DELAY_TIMER : // see [RULE10]
               need_ost ? ST_OST : ST_PIN; // see [RULE19]
         ST_POWERUP_DELAY_TIMER: if (powerup_delay_timer_cnt_reg == PW'(POWERUP_DELAY_TIMER_TICKS)) // see [RULE9]
            state_next = need_ost ? ST_OST : ST_PIN; // see [RULE12]
         ST_OST: if (ost_cnt_reg == OW'(OST_CYCLES))
            state_next = ST_PIN;
         ST_PIN: if (!pin_raw_low) state_next = ST_RUN; // see [RULE20]
         ST_RUN: state_next = ST_RUN;
      endcase
      if (supply_low && state_reg == ST_POWERUP_DELAY_TIMER) state_next = ST_HOLD; // see [RULE17]
      if (wdt_wake && state_reg == ST_RUN) state_next = crystal ? ST_OST : ST_RUN;
      if (hard_rst) state_next = ST_HOLD; // see [RULE23]
   end

   // sequencer and timers
   always_ff @(posedge SYS_CLK_I)
   begin
      if (RST_I)
      begin
         state_reg <= ST_HOLD;
         powerup_delay_timer_cnt_reg <= '0;
         ost_cnt_reg <= '0;
         osc_prev_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         osc_prev_reg <= OSCILLATOR_INPUT_PIN_I;
         powerup_delay_timer_cnt_reg <= (state_reg != ST_POWERUP_DELAY_TIMER || state_next != ST_POWERUP_DELAY_TIMER) ? '0 :
            powerup_delay_timer_cnt_reg + PW'(PWRUP_RC_TICK_I); // see [RULE9]
         ost_cnt_reg <= (state_reg != ST_OST || state_next != ST_OST) ? '0 :
            ost_cnt_reg + OW'(osc_edge); // see [RULE12]
      end
   end

   // pin glitch filter and dip timer
   always_ff @(posedge SYS_CLK_I)
   begin
      if (RST_I)
      begin
         filt_cnt_reg <= '0;
         pin_low_reg <= 1'b0;
         bod_cnt_reg <= '0;
      end
      else
      begin
         filt_cnt_reg <= !pin_raw_low ? '0 :
            (filt_cnt_reg == FW'(FILT_CYCLES)) ? filt_cnt_reg : filt_cnt_reg + 1'b1;
         pin_low_reg <= pin_raw_low && (filt_cnt_reg == FW'(FILT_CYCLES)); // see [RULE5]
         bod_cnt_reg <= !BELOW_TRIP_I ? '0 :
            (bod_cnt_reg == BW'(BOD_CYCLES)) ? bod_cnt_reg : bod_cnt_reg + 1'b1;
      end
   end

   // cause capture and status flags
   always_ff @(posedge SYS_CLK_I)
   begin
      if (RST_I)
      begin
         por_flag_reg <= 1'b0;
         bod_flag_reg <= 1'b0;
         to_flag_reg <= 1'b1;
         pd_flag_reg <= 1'b1;
         cause_reg <= CAUSE_NONE;
         by_por_reg <= 1'b1;
         sleep_reg <= 1'b0;
      end
      else
      begin
         if (POR_PULSE_I)
         begin
            cause_reg <= CAUSE_POR;
            by_por_reg <= 1'b1;
            por_flag_reg <= 1'b0; // see [RULE21]
            to_flag_reg <= 1'b1; // see [RULE4]
            pd_flag_reg <= 1'b1;
            sleep_reg <= 1'b0;
         end
         else if (bod_evt)
         begin
            cause_reg <= CAUSE_BOD;
            by_por_reg <= 1'b1;
            bod_flag_reg <= 1'b0; // see [RULE22]
            to_flag_reg <= 1'b1; // see [RULE4]
            pd_flag_reg <= 1'b1;
            sleep_reg <= 1'b0;
         end
         else if (master_clear_pin_evt)
         begin
            cause_reg <= sleep_reg ? CAUSE_MASTER_CLEAR_PIN_SLEEP : CAUSE_MASTER_CLEAR_PIN_RUN;
            by_por_reg <= 1'b0;
            if (sleep_reg)
            begin
               to_flag_reg <= 1'b1; // see [RULE4]
               pd_flag_reg <= 1'b0;
            end
            sleep_reg <= 1'b0;
         end
         else if (wdt_run)
         begin
            cause_reg <= CAUSE_WDT;
            by_por_reg <= 1'b0;
            to_flag_reg <= 1'b0; // see [RULE4]
         end
         else if (wdt_wake)
         begin
            cause_reg <= CAUSE_WDT_WAKE;
            by_por_reg <= 1'b0;
            to_flag_reg <= 1'b0; // see [RULE4]
            pd_flag_reg <= 1'b0;
            sleep_reg <= 1'b0;
         end
         else if (apb_wr && sel_stat)
         begin
            por_flag_reg <= PWDATA[`STAT_POR_BIT];
            bod_flag_reg <= PWDATA[`STAT_BOD_BIT];
         end
         else if (apb_wr && sel_ctrl)
            sleep_reg <= PWDATA[`CTRL_SLEEP_BIT];
      end
   end

   // register block and outputs
   always_ff @(posedge SYS_CLK_I)
   begin
      if (RST_I)
      begin
         state_rst_reg <= `CTRL_STATE_RST;
         PRDATA <= 32'h0000_0000;
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         CHIP_RESET_O <= 1'b1;
         STATE_RESET_O <= 1'b1;
         WAKE_O <= 1'b0;
         MASTER_CLEAR_PIN_OE_O <= 1'b0;
      end
      else
      begin
         PREADY <= PSEL && PENABLE && !PREADY;
         PSLVERR <= PSEL && PENABLE && !PREADY && !mapped;
         if (apb_rd) PRDATA <= rd_mux;
         if (hard_rst) state_rst_reg <= `CTRL_STATE_RST; // see [RULE3]
         CHIP_RESET_O <= state_next != ST_RUN; // see [RULE23]
         STATE_RESET_O <= hard_rst || (state_reg == ST_HOLD); // see [RULE3]
         WAKE_O <= wdt_wake;
         MASTER_CLEAR_PIN_OE_O <= 1'b0; // see [RULE6]
      end
   end

   // retained register: no reset of any kind
   always_ff @(posedge SYS_CLK_I)
   begin
      if (apb_wr && sel_ret) retain_reg <= PWDATA[7:0]; // see [RULE2]
   end

   // pin never driven by the block
   a_wdt_no_pin: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // see [RULE6]
      !MASTER_CLEAR_PIN_OE_O)
      else $error("pin driven");

   // power-on pulse holds the chip
   a_por_hold: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // see [RULE7]
      POR_PULSE_I |=> CHIP_RESET_O)
      else $error("reset not held");

   // delay runs to its full count
   a_powerup_delay_timer_full: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // see [RULE9]
      (state_reg == ST_POWERUP_DELAY_TIMER && powerup_delay_timer_cnt_reg != PW'(POWERUP_DELAY_TIMER_TICKS) && !hard_rst && !supply_low)
      |=> state_reg == ST_POWERUP_DELAY_TIMER) else $error("delay cut short");

   // oscillator wait only where it applies
   a_ost_after: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // see [RULE13]
      (state_reg == ST_OST) |-> need_ost)
      else $error("osc wait");

   // dip during delay goes back to hold
   a_dip_restart: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // see [RULE17]
      (state_reg == ST_POWERUP_DELAY_TIMER && supply_low) |=> state_reg == ST_HOLD)
      else $error("no restart");

   // any new reset restarts the sequence
   a_new_reset: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // see [RULE23]
      hard_rst |=> (state_reg == ST_HOLD && CHIP_RESET_O))
      else $error("restart lost");

   // power-on flag pattern
   a_por_flag: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // see [RULE21]
      POR_PULSE_I |=> !por_flag_reg && to_flag_reg && pd_flag_reg)
      else $error("por flags");

   // brown-out clears its flag
   a_bod_flag: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // see [RULE22]
      (bod_evt && !POR_PULSE_I) |=> !bod_flag_reg)
      else $error("bod flag");

   // a fresh low edge never resets at once
   a_pin_filter: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // see [RULE5]
      $rose(pin_raw_low) |=> !master_clear_pin_evt)
      else $error("glitch passed");

   // ready stands for one cycle only
   a_ready_pulse: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // see [RULE4]
      PREADY |=> !PREADY)
      else $error("ready stuck");

   // unmapped access answered with error
   a_apb_unmapped: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // see [RULE4]
      (PSEL && PENABLE && !PREADY && !mapped) |=> PSLVERR && PREADY)
      else $error("no slave error");

   // error only together with ready
   a_err_ready: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // see [RULE4]
      PSLVERR |-> PREADY)
      else $error("error without ready");

   // ready only after an access cycle
   a_ready_access: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // see [RULE4]
      PREADY |-> $past(PSEL && PENABLE))
      else $error("ready without access");

   // chip released when run is reached
   a_run_release: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // see [RULE23]
      (state_next == ST_RUN) |=> !CHIP_RESET_O)
      else $error("release missing");

   // hold state loads reset state
   a_hold_state: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // see [RULE3]
      (state_reg == ST_HOLD) |=> STATE_RESET_O)
      else $error("state reset missing");

   // watchdog wake keeps register state
   a_wake_keeps: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // see [RULE3]
      (wdt_wake && !hard_rst && state_reg == ST_RUN) |=> !STATE_RESET_O && WAKE_O)
      else $error("wake reset state");

   // watchdog wake flag pattern
   a_wake_flags: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // see [RULE4]
      (wdt_wake && !POR_PULSE_I && !bod_evt && !master_clear_pin_evt) |=> !to_flag_reg && !pd_flag_reg)
      else $error("wake flags");

   // watchdog reset flag pattern
   a_wdt_flags: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // see [RULE4]
      (wdt_run && !POR_PULSE_I && !bod_evt && !master_clear_pin_evt) |=> !to_flag_reg)
      else $error("watchdog flags");

   // pin reset in sleep flag pattern
   a_master_clear_pin_sleep: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // see [RULE4]
      (master_clear_pin_evt && sleep_reg && !POR_PULSE_I && !bod_evt)
      |=> cause_reg == CAUSE_MASTER_CLEAR_PIN_SLEEP && to_flag_reg && !pd_flag_reg) else $error("sleep pin");

   // brown-out cause and flags
   a_bod_cause: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // see [RULE1]
      (bod_evt && !POR_PULSE_I) |=> cause_reg == CAUSE_BOD && to_flag_reg && pd_flag_reg)
      else $error("bod cause");

   // power-on cause recorded
   a_por_cause: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // see [RULE1]
      POR_PULSE_I |=> cause_reg == CAUSE_POR)
      else $error("por cause");

   // power-on flag kept by other events
   a_por_kept: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // see [RULE21]
      (!POR_PULSE_I && !(apb_wr && sel_stat)) |=> por_flag_reg == $past(por_flag_reg))
      else $error("por flag changed");

   // delay skipped when disabled
   a_powerup_delay_timer_skip: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // see [RULE10]
      (state_reg == ST_HOLD && POWERUP_DELAY_ENABLE_N_I && !hard_rst) |=> state_reg != ST_POWERUP_DELAY_TIMER)
      else $error("delay not skipped");

   // no wait with external clock and delay off
   a_ec_no_wait: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // see [RULE19]
      (state_reg == ST_HOLD && !hard_rst && !POR_PULSE_I && !supply_low && !crystal &&
      POWERUP_DELAY_ENABLE_N_I) |=> state_reg == ST_PIN) else $error("needless wait");

   // no oscillator wait when not needed
   a_ost_gate: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // see [RULE13]
      (state_reg == ST_POWERUP_DELAY_TIMER && powerup_delay_timer_cnt_reg == PW'(POWERUP_DELAY_TIMER_TICKS) && !need_ost && !hard_rst &&
      !supply_low) |=> state_reg == ST_PIN) else $error("osc wait taken");

   // low pin holds the finished sequence
   a_pin_wait: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // see [RULE20]
      (state_reg == ST_PIN && pin_raw_low && !hard_rst) |=> state_reg == ST_PIN)
      else $error("left with pin low");

   // hold until supply is back
   a_hold_supply: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // see [RULE16]
      (state_reg == ST_HOLD && supply_low) |=> state_reg == ST_HOLD)
      else $error("left hold early");

   // long dip resets the chip
   a_dip_reset: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // see [RULE15]
      (BROWNOUT_ENABLE_I && bod_cnt_reg == BW'(BOD_CYCLES)) |=> state_reg == ST_HOLD && STATE_RESET_O)
      else $error("dip ignored");
endmodule // reset_timeout_sequencer

/* File: rtl/rst_seq_params.svh */
// Operation
// [RULE1] five reset causes told apart
// [RULE2] retained group unknown on power-on only
// [RULE3] reset state except on watchdog wake
// [RULE4] timeout and power-down flags per cause
// [RULE5] master-clear pin filtered against short pulses
// [RULE6] watchdog reset never drives the pin
// [RULE7] hold reset until supply is adequate; code checks SUPPLY_OK_I only when brown-out is enabled
// [RULE8] power-on detector ignores supply decline
// [RULE9] 72 ms delay after power-on or brown-out
// [RULE10] delay enable bit is active low
// [RULE11] configure delay on when brown-out enabled
// [RULE12] then 1024 oscillator pin cycles
// [RULE13] oscillator delay crystal modes, power-on/wake only; code also runs it after brown-out
// [RULE14] brown-out enable bit is active high
// [RULE15] long supply dips cause brown-out reset
// [RULE16] wait for release level, then delay
// [RULE17] dip during delay restarts full delay
// [RULE18] delay after power-on pulse, then oscillator
// [RULE19] external clock, delay off: no wait
// [RULE20] delays run regardless of pin level
// [RULE21] power-on flag cleared by power-on only
// [RULE22] brown-out flag cleared by brown-out only
// [RULE23] new reset restarts whole sequence
`ifndef RST_SEQ_PARAMS_SVH
`define RST_SEQ_PARAMS_SVH
`define PWRUP_DELAY_MS 72
`define PWRUP_RC_HZ 32000
`define OSC_STARTUP_CYCLES 1024
`define MASTER_CLEAR_PIN_FILTER_CYCLES 8
`define BOD_MIN_CYCLES 4
`define REG_CTRL 32'h0000_0000
`define REG_STATUS 32'h0000_0004
`define REG_RETAIN 32'h0000_0008
`define STAT_POR_BIT 0
`define STAT_BOD_BIT 1
`define STAT_TO_BIT 2
`define STAT_PD_BIT 3
`define STAT_CAUSE_LSB 4
`define CTRL_SLEEP_BIT 0
`define CTRL_STATE_RST 8'h00
`endif

/* File: rtl/rst_seq_pkg.sv */
package rst_seq_pkg;
   typedef enum logic [2:0] {
      OSC_LP, OSC_XT, OSC_HS, OSC_EC, OSC_INT_IO, OSC_INT_CK, OSC_RC_IO, OSC_RC_CK
   } osc_mode_e;
   typedef enum logic [2:0] {
      CAUSE_NONE, CAUSE_POR, CAUSE_MASTER_CLEAR_PIN_RUN, CAUSE_MASTER_CLEAR_PIN_SLEEP, CAUSE_WDT, CAUSE_BOD,
      CAUSE_WDT_WAKE
   } cause_e;
   typedef enum {
      ST_HOLD, ST_POWERUP_DELAY_TIMER, ST_OST, ST_PIN, ST_RUN
   } seq_state_e;
endpackage

/* File: testbench/reset_timeout_sequencer_bench.sv */
`timescale 1ns/1ps
`include "rst_seq_params.svh"
`define CHK(what, exp, got) \
   begin \
      num_checks++; \
      if ((got) !== (exp)) \
      begin \
         fails++; \
         $display("wrong value %s expected %h seen %h", what, exp, got); \
      end \
   end
module reset_timeout_sequencer_bench;
   import rst_seq_pkg::*;
   // startup table: mode, delay off, bounds; pin held low in the last entry only
   localparam logic [2:0] MODES [5] = '{OSC_XT, OSC_EC, OSC_EC, OSC_XT, OSC_XT};
   localparam logic OFFS [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
   localparam int LOS [5] = '{56, 28, 0, 28, 0};
   localparam int HIS [5] = '{84, 52, 6, 52, 6};
   logic clk = 1'b0, rst = 1'b1, por = 1'b1, low = 1'b0, pin_n = 1'b1, wdt = 1'b0;
   logic powerup_delay_timer_n = 1'b0, bod_en = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [2:0] mode = OSC_XT;
   logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
   logic pready, pslverr, err, chip_rst, state_rst, wake, pin_oe, ok_w, trip_w, osc_w, tick_w;
   int fails = 0, num_checks = 0, n, hi_cnt = 0, st_cnt = 0, wk_cnt = 0, h, s, w;
   reset_timeout_sequencer #(.POWERUP_DELAY_TIMER_MS(1), .RC_HZ(8000), .OST_CYCLES(8))
   reset_timeout_sequencer_inst (.SYS_CLK_I(clk), .RST_I(rst), .POR_PULSE_I(por),
      .SUPPLY_OK_I(ok_w), .BELOW_TRIP_I(trip_w), .MASTER_CLEAR_PIN_N_I(pin_n),
      .OSCILLATOR_INPUT_PIN_I(osc_w), .PWRUP_RC_TICK_I(tick_w),
      .WATCHDOG_TIMER_EXPIRE_I(wdt), .POWERUP_DELAY_ENABLE_N_I(powerup_delay_timer_n),
      .BROWNOUT_ENABLE_I(bod_en), .MASTER_CLEAR_PIN_PIN_ENABLE_I(1'b1), .OSC_MODE_I(mode),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .CHIP_RESET_O(chip_rst),
      .STATE_RESET_O(state_rst), .WAKE_O(wake), .MASTER_CLEAR_PIN_OE_O(pin_oe));
   supply_pin_model supply_pin_model_inst (.clk_i(clk), .supply_low_i(low),
      .supply_ok_o(ok_w), .below_trip_o(trip_w), .osc_pin_o(osc_w), .rc_tick_o(tick_w));
   // 40 MHz clock
   initial
   begin
      forever #12.5 clk = ~clk;
   end
   // activity counters
   always @(posedge clk)
   begin
      hi_cnt += (chip_rst === 1'b1);
      st_cnt += (state_rst === 1'b1);
      wk_cnt += (wake === 1'b1);
   end
   task automatic final_report();
      if (fails == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // one apb transfer, entered just after a rising edge
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wait_run();
      n = 0;
      while (chip_rst !== 1'b0 && n < 400)
      begin
         @(posedge clk);
         n++;
      end
   endtask
   task automatic stat(input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, `REG_STATUS, '0);
      `CHK("status", e, rd & m)
   endtask
   task automatic pulse(input int m, input logic wd);
      pin_n <= wd;
      wdt <= wd;
      repeat (m) @(posedge clk);
      pin_n <= 1'b1;
      wdt <= 1'b0;
      repeat (3) @(posedge clk);
      wait_run();
   endtask
   // bounded run
   initial
   begin
      repeat (20000) @(posedge clk);
      fails++;
      final_report();
   end
   initial
   begin
      // power-on in each startup configuration
      for (int i = 0; i < 5; i++)
      begin
         rst <= 1'b1;
         por <= 1'b1;
         mode <= MODES[i];
         powerup_delay_timer_n <= OFFS[i];
         pin_n <= (i != 4);
         repeat (5) @(posedge clk);
         rst <= 1'b0;
         repeat (3) @(posedge clk);
         por <= 1'b0;
         @(posedge clk);
         if (i == 4)
         begin
            repeat (120) @(posedge clk);
            pin_n <= 1'b1;
            @(posedge clk);
         end
         wait_run();
         `CHK("startup", 1'b1, n >= LOS[i] && n <= HIS[i])
      end
      stat(32'h0000_007D, 32'h0000_001C);
      apb(1'b1, `REG_STATUS, 32'h0000_0003);
      apb(1'b1, `REG_RETAIN, 32'h0000_00A5);
      h = hi_cnt;
      pin_n <= 1'b0;
      repeat (5) @(posedge clk);
      pin_n <= 1'b1;
      repeat (20) @(posedge clk);
      `CHK("short pin", h, hi_cnt)
      s = st_cnt;
      pulse(12, 1'b0);
      `CHK("pin state", 1'b1, st_cnt > s)
      stat(32'h0000_007D, 32'h0000_002D);
      apb(1'b0, `REG_RETAIN, '0);
      `CHK("retain", 32'h0000_00A5, rd)
      pulse(1, 1'b1);
      `CHK("pin drive", 1'b0, pin_oe)
      stat(32'h0000_007D, 32'h0000_0049);
      apb(1'b1, `REG_CTRL, 32'h0000_0001);
      pulse(12, 1'b0);
      stat(32'h0000_007D, 32'h0000_0035);
      apb(1'b1, `REG_CTRL, 32'h0000_0001);
      s = st_cnt;
      w = wk_cnt;
      pulse(1, 1'b1);
      `CHK("wake state", s, st_cnt)
      `CHK("wake pulse", w + 1, wk_cnt)
      stat(32'h0000_007D, 32'h0000_0061);
      // brown-out with the delay enabled beside it
      mode <= OSC_EC;
      powerup_delay_timer_n <= 1'b0;
      bod_en <= 1'b1;
      h = hi_cnt;
      low <= 1'b1;
      repeat (2) @(posedge clk);
      low <= 1'b0;
      repeat (10) @(posedge clk);
      `CHK("short dip", h, hi_cnt)
      low <= 1'b1;
      repeat (10) @(posedge clk);
      low <= 1'b0;
      repeat (24) @(posedge clk);
      low <= 1'b1;
      repeat (10) @(posedge clk);
      low <= 1'b0;
      @(posedge clk);
      wait_run();
      `CHK("dip restart", 1'b1, n >= 28 && n <= 52)
      stat(32'h0000_007F, 32'h0000_005D);
      apb(1'b0, 32'h0000_0010, '0);
      `CHK("unmapped", 33'h1_0000_0000, {err, rd})
      final_report();
   end
endmodule // reset_timeout_sequencer_bench

/* File: testbench/supply_pin_model.sv */
`timescale 1ns/1ps
module supply_pin_model (
   input wire logic clk_i,
   input wire logic supply_low_i,
   output logic supply_ok_o,
   output logic below_trip_o,
   output logic osc_pin_o,
   output logic rc_tick_o
);
   logic [1:0] div_reg = 2'b00;
   // one supply level feeds both monitors
   assign supply_ok_o = !supply_low_i;
   assign below_trip_o = supply_low_i;
   // crystal and rc oscillators run free
   always_ff @(posedge clk_i)
   begin
      div_reg <= div_reg + 2'd1;
   end
   assign osc_pin_o = div_reg[1];
   assign rc_tick_o = (div_reg == 2'd3);
endmodule // supply_pin_model
